/* core/synth_ctrl_pkg.sv */
`default_nettype none
package synth_ctrl_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  MAIN_CONTROL_IDX      = 8'h00;
  localparam logic [7:0]  CAL_CLOCK_CONTROL_IDX = 8'h01;
  localparam logic [15:0] MAIN_CONTROL_RESET    = 16'h200c;
  localparam logic [15:0] CAL_CLOCK_RESET       = 16'h080c;

  // main control field positions
  localparam int PHASE_ALIGN_BIT  = 14;
  localparam int OUT_MUTE_BIT     = 9;
  localparam int RATE_ADJ_LSB     = 7;
  localparam int FREQ_CAL_BIT     = 3;
  localparam int SRC_SELECT_BIT   = 2;
  localparam int SOFT_RESET_BIT   = 1;
  // calibration clock control field positions
  localparam int DRIVE_CTRL_BIT   = 3;
  localparam int CLK_DIV_LSB      = 0;

  // cycles the sync pulse and the calibration-start pulse stay high
  localparam int SYNC_PULSE_CYCLES = 1;

  typedef struct packed {
    logic       phase_align_enable;
    logic       mute_enable;
    logic [1:0] cal_detector_rate_adjust;
    logic       status_pin_source_select;
    logic       status_pin_drive_control;
    logic [2:0] cal_clk_div;
    logic       soft_reset;
  } ctrl_fields_t;

endpackage
`default_nettype wire

/* core/synth_main_control_regs.sv */
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module synth_main_control_regs
  import synth_ctrl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lock_detect_in,
  input  wire logic        readback_data_in,
  input  wire logic        vco_calibrating_in,
  output logic             phase_align_enable,
  output logic             sync_pulse,
  output logic             freq_cal_start,
  output logic             radio_output_mute,
  output logic [1:0]       cal_detector_rate_adjust,
  output logic [2:0]       cal_clk_div,
  output logic             core_reset,
  output logic             status_output_pin_o,
  output logic             status_output_pin_oe_n
);

  logic [15:0] main_reg, main_next;
  logic [15:0] calclk_reg, calclk_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;
  logic        sync_reg, sync_next;
  logic        cal_reg, cal_next;
  logic        mute_reg, mute_next;
  logic        pin_reg, pin_next;
  logic        pin_oe_n_reg, pin_oe_n_next;
  logic        pready_reg, pready_next;
  logic [1:0]  lock_sync_reg, lock_sync_next;
  logic [1:0]  rb_sync_reg, rb_sync_next;
  logic [1:0]  cal_sync_reg, cal_sync_next;
  ctrl_fields_t f;

  logic access, setup_phase, wr_main, wr_cal, hit_main, hit_cal;
  logic [15:0] wdata16;

  // zero-wait slave: every access completes in its first access cycle
  assign access   = psel && penable;
  // the setup cycle is where the read answer is prepared, one edge ahead of the access edge
  assign setup_phase = psel && !penable;
  assign hit_main = (paddr[11:2] == 10'(MAIN_CONTROL_IDX)) && (paddr[1:0] == 2'h0);
  assign hit_cal  = (paddr[11:2] == 10'(CAL_CLOCK_CONTROL_IDX)) && (paddr[1:0] == 2'h0);
  assign wr_main  = access && pwrite && hit_main;
  assign wr_cal   = access && pwrite && hit_cal;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0])
      r[7:0] = wd[7:0];
    if (st[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  always_comb
  begin
    wdata16 = 16'h0000;
    f = '0;
    f.phase_align_enable       = main_reg[PHASE_ALIGN_BIT];
    f.mute_enable              = main_reg[OUT_MUTE_BIT];
    f.cal_detector_rate_adjust = main_reg[RATE_ADJ_LSB +: 2];
    f.status_pin_source_select = main_reg[SRC_SELECT_BIT];
    f.soft_reset               = main_reg[SOFT_RESET_BIT];
    f.status_pin_drive_control = calclk_reg[DRIVE_CTRL_BIT];
    f.cal_clk_div              = calclk_reg[CLK_DIV_LSB +: 3];

    main_next   = main_reg;
    calclk_next = calclk_reg;
    // soft reset holds the cal clock word at its default and the main word at its default with the soft reset bit set; only the main word stays writable
    if (f.soft_reset)
    begin
      main_next   = MAIN_CONTROL_RESET | (16'h0001 << SOFT_RESET_BIT);
      calclk_next = CAL_CLOCK_RESET;
    end
    if (wr_main)
      main_next = merge(main_reg, pwdata, pstrb);
    else if (wr_cal && !f.soft_reset)
      calclk_next = merge(calclk_reg, pwdata, pstrb);
    wdata16 = merge(main_reg, pwdata, pstrb);

    // phase-align edge: rising only, written value vs stored one
    sync_next = wr_main && wdata16[PHASE_ALIGN_BIT] && !main_reg[PHASE_ALIGN_BIT];
    // a write with the trigger bit set and the soft reset bit clear starts calibration even if it was already set
    cal_next  = wr_main && wdata16[FREQ_CAL_BIT] && !wdata16[SOFT_RESET_BIT];

    mute_next = f.mute_enable && cal_sync_reg[1];
    pin_next  = f.status_pin_source_select ? lock_sync_reg[1] : rb_sync_reg[1];
    pin_oe_n_next = !f.status_pin_drive_control;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_reg      <= MAIN_CONTROL_RESET;
      calclk_reg    <= CAL_CLOCK_RESET;
      sync_reg      <= 1'b0;
      cal_reg       <= 1'b0;
      mute_reg      <= 1'b0;
      pin_reg       <= 1'b0;
      pin_oe_n_reg  <= 1'b0;
    end
    else
    begin
      main_reg      <= main_next;
      calclk_reg    <= calclk_next;
      sync_reg      <= sync_next;
      cal_reg       <= cal_next;
      mute_reg      <= mute_next;
      pin_reg       <= pin_next;
      pin_oe_n_reg  <= pin_oe_n_next;
    end
  end

  // pin inputs: two flops each; only the second flop feeds the mute and status logic
  always_comb
  begin
    lock_sync_next = {lock_sync_reg[0], lock_detect_in};
    rb_sync_next   = {rb_sync_reg[0], readback_data_in};
    cal_sync_next  = {cal_sync_reg[0], vco_calibrating_in};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_sync_reg <= 2'h0;
      rb_sync_reg   <= 2'h0;
      cal_sync_reg  <= 2'h0;
    end
    else
    begin
      lock_sync_reg <= lock_sync_next;
      rb_sync_reg   <= rb_sync_next;
      cal_sync_reg  <= cal_sync_next;
    end
  end

  // bus response: read data and error are decoded in the setup cycle and registered with pready,
  // so all three already stand at the edge where the master samples pready high;
  // safe, since a write lands only at an access edge, never between setup and access
  always_comb
  begin
    pready_next  = setup_phase;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (setup_phase)
    begin
      if (hit_main)
        prdata_next = {16'h0000, main_reg};
      else if (hit_cal)
        prdata_next = {16'h0000, calclk_reg};
      else
      begin
        // unmapped or misaligned: read zero and flag it; the write path ignores it too
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end
    else
    begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg  <= pready_next;
    end
  end

  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;
  assign pready   = pready_reg;
  assign phase_align_enable       = main_reg[PHASE_ALIGN_BIT];
  assign sync_pulse               = sync_reg;
  assign freq_cal_start           = cal_reg;
  assign radio_output_mute        = mute_reg;
  assign cal_detector_rate_adjust = main_reg[RATE_ADJ_LSB +: 2];
  assign cal_clk_div              = calclk_reg[CLK_DIV_LSB +: 3];
  assign core_reset               = main_reg[SOFT_RESET_BIT];
  assign status_output_pin_o      = pin_reg;
  assign status_output_pin_oe_n   = pin_oe_n_reg;

endmodule // synth_main_control_regs
`default_nettype wire

/* verif/synth_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module synth_regs_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        phase_align_enable,
  input wire logic        sync_pulse,
  input wire logic        freq_cal_start,
  input wire logic        core_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pstrb is not watched: the bench always writes whole words
  wire w0 = psel && penable && pwrite && paddr == 12'h000;
  sync_edge_a: assert property ($rose(phase_align_enable) == sync_pulse) else $error("bad sync");
  sync_single_a: assert property (sync_pulse |=> !sync_pulse) else $error("long sync");
  align_follow_a: assert property (w0 && !pwdata[1] |=> phase_align_enable == $past(pwdata[14]))
    else $error("bad align");
  cal_start_a: assert property (w0 && pwdata[3] && !pwdata[1] |=> freq_cal_start) else $error("no cal");
  cal_cause_a: assert property (freq_cal_start |-> $past(w0) && $past(pwdata[3])) else $error("stray cal");
  reset_bit_a: assert property (w0 |=> core_reset == $past(pwdata[1])) else $error("bad reset");
  reset_hold_a: assert property (core_reset && !w0 |=> core_reset) else $error("reset lost");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h004 |-> pslverr) else $error("no err");
  cover property (sync_pulse);
  cover property (freq_cal_start);
  cover property (core_reset ##1 !core_reset);
endmodule // synth_regs_properties
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import synth_ctrl_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, p14 = 0;
  logic        lock_detect_in = 0, readback_data_in = 0, vco_calibrating_in = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, d;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, phase_align_enable, sync_pulse, freq_cal_start, radio_output_mute;
  logic        core_reset, status_output_pin_o, status_output_pin_oe_n;
  logic [1:0]  cal_detector_rate_adjust;
  logic [2:0]  cal_clk_div;
  logic [31:0] exp_q[$];
  logic        sync_seen = 0, cal_seen = 0;
  int          fail_count = 0, compares = 0, cyc = 0;
  synth_main_control_regs dut (.*);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000) stop_test();
  end
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, exp_q.pop_front());
    if (psel && penable && pready === 1'b1) check(pslverr, paddr > 12'h004);
  end
  // pulses stand one cycle only, so they are caught at the falling edge
  always @(negedge pclk)
  begin
    if (sync_pulse === 1'b1) sync_seen = 1'b1;
    if (freq_cal_start === 1'b1) cal_seen = 1'b1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // v is write data, or the expected word for a read
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) exp_q.push_back(v);
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stop_test();
    if (cyc >= 3000) fail_count++;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    r = $urandom(16);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(0, 12'h000, 32'h200c);
    bus(0, 12'h004, 32'h080c);
    check(cal_clk_div, 3'h4);
    $display("reset values done");
    cal_seen = 1'b0;
    bus(1, 12'h000, 32'h200e);
    check(core_reset, 1'b1);
    check(cal_seen, 1'b0);
    bus(1, 12'h004, 32'h0000);
    bus(0, 12'h004, 32'h080c);
    cal_seen = 1'b0;
    bus(1, 12'h000, 32'h2010);
    check(core_reset, 1'b0);
    check(cal_seen, 1'b0);
    $display("soft reset done");
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      d = 32'h2010 | (i << 7) | (r & 32'hc20d);
      vco_calibrating_in <= r[20];
      lock_detect_in <= r[21];
      readback_data_in <= r[22];
      sync_seen = 1'b0;
      cal_seen = 1'b0;
      bus(1, 12'h000, d);
      check(sync_seen, d[14] & !p14);
      check(cal_seen, d[3]);
      check(phase_align_enable, d[14]);
      check(cal_detector_rate_adjust, i[1:0]);
      p14 = d[14];
      bus(0, 12'h000, d);
      check(radio_output_mute, d[9] & r[20]);
      check(status_output_pin_o, d[2] ? r[21] : r[22]);
    end
    $display("field tests done");
    bus(0, 12'h008, 32'h0000);
    bus(1, 12'h004, 32'h0800);
    bus(0, 12'h004, 32'h0800);
    check(status_output_pin_oe_n, 1'b1);
    check(cal_clk_div, 3'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(0, 12'h000, 32'h200c);
    bus(0, 12'h004, 32'h080c);
    check(status_output_pin_oe_n, 1'b0);
    check(cal_clk_div, 3'h4);
    $display("second reset done");
    stop_test();
  end
endmodule // testbench
bind synth_main_control_regs synth_regs_properties props (.*);
`default_nettype wire
